// ### src/uirq_cfg.svh
`ifndef UIRQ_CFG_SVH
`define UIRQ_CFG_SVH

// register word indices; byte address is four times the index
`define UIRQ_RISE_WR      8'h0D
`define UIRQ_RISE_SET     8'h0E
`define UIRQ_RISE_CLR     8'h0F
`define UIRQ_FALL_WR      8'h10
`define UIRQ_FALL_SET     8'h11
`define UIRQ_FALL_CLR     8'h12
`define UIRQ_STATUS       8'h13
`define UIRQ_LATCH        8'h14
`define UIRQ_LINE_VIEW    8'h15
`define UIRQ_SCR_WR       8'h16
`define UIRQ_SCR_SET      8'h17
`define UIRQ_SCR_CLR      8'h18
`define UIRQ_ACC_WR       8'h19
`define UIRQ_ACC_SET      8'h1A
`define UIRQ_ACC_CLR      8'h1B
`define UIRQ_AIE_WR       8'h1D
`define UIRQ_AIE_SET      8'h1E
`define UIRQ_AIE_CLR      8'h1F
`define UIRQ_MODE_CTRL    8'h20
`define UIRQ_HOLE         8'h1C

// reset values
`define UIRQ_EDGE_EN_RST  8'h1F
`define UIRQ_SCR_RST      8'h00
`define UIRQ_ACC_RST      8'h00
`define UIRQ_AIE_RST      8'h00

// field positions and masks
`define UIRQ_SRC_MASK     8'h1F
`define UIRQ_VBUS_BIT     1
`define UIRQ_SEND_BIT     3
`define UIRQ_ACC_MASK     8'hFE
`define UIRQ_AIE_MASK     8'h07
`define UIRQ_IDGND_BIT    1
`define UIRQ_TXD_BIT      2
`define UIRQ_RXD_BIT      3
`define UIRQ_SPKL_BIT     4
`define UIRQ_SPKR_BIT     5
`define UIRQ_MIC_BIT      6
`define UIRQ_D2TRI_BIT    7
`define UIRQ_FLT_ON_BIT   0
`define UIRQ_FLT_OFF_BIT  1
`define UIRQ_VDAT_BIT     2

`endif

// ### src/uirq_pkg.sv
package uirq_pkg;
    typedef logic [7:0] uirq_byte_t;
    typedef logic [4:0] uirq_src_t;
    typedef enum logic [1:0] {
        UIRQ_WR_LOAD,
        UIRQ_WR_SET,
        UIRQ_WR_CLR,
        UIRQ_WR_NONE
    } uirq_wop_e;
endpackage : uirq_pkg

// ### src/uirq_regs.sv
`timescale 1ns/1ps
`include "uirq_cfg.svh"

// Operation
// - falling enables readable 10h-12h; write loads, 11h sets, 12h clears
// - falling enable bits 0-4 cover five sources, all default one
// - status byte at 13h shows live comparator outputs
// - vbus status reads zero when both its edge enables are set
// - session end status reads zero when both edge enables set
// - session valid status always shows the live comparator
// - latch at 14h sets on enabled edges, clears on read
// - debug byte at 15h shows line state in bits 1:0
// - scratch byte at 16h-18h with load/set/clear, no side effect
// - carkit control at 19h-1Bh with load/set/clear, bit 0 zero
// - data pin 1 held high while receive routing is off
// - bit 2 routes data0 to DM, bit 3 routes DP to data1
// - bit 1 drives the ID pin to ground
// - bit 4 connects DM to the left speaker pin
// - DP connects to right speaker while bit 5 or 6 set
// - bit 7 tristates data pin 2 in carkit mode, else drives zero
// - uart data also reaches the left speaker pin when bits 2 and 4 are both on
// - single-ended receivers off while any audio switch is on
// - carkit irq enables at 1Dh-1Fh, float on and float off
// - enable bit 2 raises alt interrupt on any vdat change
// - rising enables at 0Dh-0Fh, same five sources, default one
// - carkit entry bit cleared by the device on mode exit
module uirq_regs
    import uirq_pkg::*;
(
    // clock and reset
    input  wire logic               clk_i,
    input  wire logic               rst_i,
    // wishbone slave
    input  wire logic               cyc_i,
    input  wire logic               stb_i,
    input  wire logic               we_i,
    input  wire logic [7:0]         adr_i,
    input  wire logic [3:0]         sel_i,
    input  wire logic [31:0]        dat_i,
    output logic      [31:0]        dat_o,
    output logic                    ack_o,
    output logic                    err_o,
    // comparators and line
    input  wire uirq_pkg::uirq_src_t src_i,
    input  wire logic [1:0]         line_state_i,
    input  wire logic               id_float_i,
    input  wire logic               vdat_det_i,
    input  wire logic               accessory_exit_i,
    input  wire logic               uart_txd_i,
    input  wire logic               dp_rx_i,
    // switches and pins
    output logic                    irq_event_o,
    output logic                    alt_int_o,
    output logic                    accessory_mode_entry_o,
    output logic                    id_pin_ground_drive_o,
    output logic                    dm_txd_route_o,
    output logic                    dm_txd_o,
    output logic                    dp_rxd_route_o,
    output logic                    data1_o,
    output logic                    data2_o,
    output logic                    data2_oe_o,
    output logic                    left_audio_pin_o,
    output logic                    right_audio_pin_o,
    output logic                    se_rx_enable_o
);
    import uirq_pkg::*;

    // adr_i is the word index (byte address bits 9:2)
    uirq_byte_t rise_en;
    uirq_byte_t fall_en;
    uirq_byte_t latch;
    uirq_byte_t scratch;
    uirq_byte_t acc_ctrl;
    uirq_byte_t acc_ie;
    uirq_src_t  src_q;
    logic       float_q;
    logic       vdat_q;
    logic       mode_q;

    function automatic uirq_byte_t upd(input uirq_byte_t cur,
                                       input uirq_byte_t wd,
                                       input uirq_wop_e op,
                                       input uirq_byte_t mask);
        uirq_byte_t r;
        case (op)
            UIRQ_WR_LOAD: r = wd;
            UIRQ_WR_SET:  r = cur | wd;
            UIRQ_WR_CLR:  r = cur & ~wd;
            default:      r = cur;
        endcase
        return r & mask;
    endfunction : upd

    function automatic uirq_wop_e wop(input logic [7:0] a,
                                      input logic [7:0] base);
        uirq_wop_e r;
        if (a == base) begin
            r = UIRQ_WR_LOAD;
        end else if (a == base + 8'h01) begin
            r = UIRQ_WR_SET;
        end else if (a == base + 8'h02) begin
            r = UIRQ_WR_CLR;
        end else begin
            r = UIRQ_WR_NONE;
        end
        return r;
    endfunction : wop

    wire logic       req    = cyc_i & stb_i & ~ack_o & ~err_o;
    wire logic       wr_ok  = req & we_i & sel_i[0];
    wire uirq_byte_t wdat   = dat_i[7:0];
    wire logic       in_rng = (adr_i >= `UIRQ_RISE_WR) &&
                              (adr_i <= `UIRQ_MODE_CTRL) &&
                              (adr_i != `UIRQ_HOLE);
    wire uirq_wop_e  op_r   = wr_ok ? wop(adr_i, `UIRQ_RISE_WR)
                                    : UIRQ_WR_NONE;
    wire uirq_wop_e  op_f   = wr_ok ? wop(adr_i, `UIRQ_FALL_WR)
                                    : UIRQ_WR_NONE;
    wire uirq_wop_e  op_s   = wr_ok ? wop(adr_i, `UIRQ_SCR_WR)
                                    : UIRQ_WR_NONE;
    wire uirq_wop_e  op_a   = wr_ok ? wop(adr_i, `UIRQ_ACC_WR)
                                    : UIRQ_WR_NONE;
    wire uirq_wop_e  op_i   = wr_ok ? wop(adr_i, `UIRQ_AIE_WR)
                                    : UIRQ_WR_NONE;
    wire logic       wr_mode = wr_ok && adr_i == `UIRQ_MODE_CTRL;

    // edge detection on synchronous comparator inputs
    wire uirq_src_t rise_ev = src_i & ~src_q & rise_en[4:0];
    wire uirq_src_t fall_ev = ~src_i & src_q & fall_en[4:0];
    wire uirq_src_t any_ev  = rise_ev | fall_ev;
    wire logic rd_latch = req & ~we_i && adr_i == `UIRQ_LATCH;

    // live status with the two masked bits
    wire logic vbus_mask = rise_en[`UIRQ_VBUS_BIT] & fall_en[`UIRQ_VBUS_BIT];
    wire logic send_mask = rise_en[`UIRQ_SEND_BIT] & fall_en[`UIRQ_SEND_BIT];
    wire uirq_byte_t status = {3'h0,
        src_i[4],
        src_i[3] & ~send_mask,
        src_i[2],
        src_i[1] & ~vbus_mask,
        src_i[0]};

    wire logic flt_ev = (id_float_i & ~float_q & acc_ie[`UIRQ_FLT_ON_BIT]) |
                        (~id_float_i & float_q & acc_ie[`UIRQ_FLT_OFF_BIT]);
    wire logic vdat_ev = (vdat_det_i ^ vdat_q) &
                         acc_ie[`UIRQ_VDAT_BIT];

    logic [7:0] rd_mux;
    always_comb begin
        case (adr_i)
            `UIRQ_RISE_WR, `UIRQ_RISE_SET, `UIRQ_RISE_CLR: rd_mux = rise_en;
            `UIRQ_FALL_WR, `UIRQ_FALL_SET, `UIRQ_FALL_CLR:
                rd_mux = fall_en;
            `UIRQ_STATUS:    rd_mux = status;
            `UIRQ_LATCH:     rd_mux = latch;
            `UIRQ_LINE_VIEW: rd_mux = {6'h00, line_state_i};
            `UIRQ_SCR_WR, `UIRQ_SCR_SET, `UIRQ_SCR_CLR:
                rd_mux = scratch;
            `UIRQ_ACC_WR, `UIRQ_ACC_SET, `UIRQ_ACC_CLR:
                rd_mux = acc_ctrl;
            `UIRQ_AIE_WR, `UIRQ_AIE_SET, `UIRQ_AIE_CLR:
                rd_mux = acc_ie;
            `UIRQ_MODE_CTRL: rd_mux = {7'h00, mode_q};
            default:         rd_mux = 8'h00;
        endcase
    end

    // pin routing, combinational from the control byte
    wire logic audio_on = acc_ctrl[`UIRQ_SPKL_BIT] |
                          acc_ctrl[`UIRQ_SPKR_BIT] |
                          acc_ctrl[`UIRQ_MIC_BIT];
    wire logic uart_dm  = acc_ctrl[`UIRQ_TXD_BIT] ? uart_txd_i : 1'b0;
    wire logic dp_r_on  = acc_ctrl[`UIRQ_SPKR_BIT] |
                          acc_ctrl[`UIRQ_MIC_BIT];

    // named next values for the registered pins
    wire logic next_data1    = acc_ctrl[`UIRQ_RXD_BIT] ? dp_rx_i : 1'b1;
    wire logic next_data2_oe = ~(mode_q & acc_ctrl[`UIRQ_D2TRI_BIT]);
    wire logic next_left     = acc_ctrl[`UIRQ_SPKL_BIT] & uart_dm;
    wire logic next_right    = dp_r_on & dp_rx_i;
    wire logic [31:0] next_dat = (req & ~we_i) ? {24'h00_0000, rd_mux}
                                               : 32'h0000_0000;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rise_en <= `UIRQ_EDGE_EN_RST;
        end else begin
            rise_en <= upd(rise_en, wdat, op_r, `UIRQ_SRC_MASK);
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            fall_en <= `UIRQ_EDGE_EN_RST;
        end else begin
            fall_en <= upd(fall_en, wdat, op_f, `UIRQ_SRC_MASK);
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            scratch <= `UIRQ_SCR_RST;
        end else begin
            scratch <= upd(scratch, wdat, op_s, 8'hFF);
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            acc_ctrl <= `UIRQ_ACC_RST;
        end else begin
            acc_ctrl <= upd(acc_ctrl, wdat, op_a, `UIRQ_ACC_MASK);
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            acc_ie <= `UIRQ_AIE_RST;
        end else begin
            acc_ie <= upd(acc_ie, wdat, op_i, `UIRQ_AIE_MASK);
        end
    end

    // a new event wins over the clearing read
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            latch <= 8'h00;
        end else begin
            latch <= (rd_latch ? 8'h00 : latch) |
                     {3'h0, any_ev};
        end
    end

    // exit from the accessory mode beats a software write in the same cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mode_q <= 1'b0;
        end else if (accessory_exit_i) begin
            mode_q <= 1'b0;
        end else if (wr_mode) begin
            mode_q <= wdat[0];
        end
    end

    // history flops run through reset: a level already high when reset
    // ends raises no false edge
    always_ff @(posedge clk_i) begin
        src_q   <= src_i;
        float_q <= id_float_i;
        vdat_q  <= vdat_det_i;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
            err_o <= 1'b0;
        end else begin
            ack_o <= req & in_rng;
            err_o <= req & ~in_rng;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_o <= 32'h0000_0000;
        end else begin
            dat_o <= next_dat;
        end
    end

    // each pin output leaves its own flip-flop, one cycle behind its source
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_event_o <= 1'b0;
        end else begin
            irq_event_o <= |any_ev;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            alt_int_o <= 1'b0;
        end else begin
            alt_int_o <= flt_ev | vdat_ev;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            accessory_mode_entry_o <= 1'b0;
        end else begin
            accessory_mode_entry_o <= mode_q;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            id_pin_ground_drive_o <= 1'b0;
        end else begin
            id_pin_ground_drive_o <= acc_ctrl[`UIRQ_IDGND_BIT];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dm_txd_route_o <= 1'b0;
        end else begin
            dm_txd_route_o <= acc_ctrl[`UIRQ_TXD_BIT];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dm_txd_o <= 1'b0;
        end else begin
            dm_txd_o <= uart_dm;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dp_rxd_route_o <= 1'b0;
        end else begin
            dp_rxd_route_o <= acc_ctrl[`UIRQ_RXD_BIT];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            data1_o <= 1'b1;
        end else begin
            data1_o <= next_data1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            data2_o <= 1'b0;
        end else begin
            data2_o <= 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            data2_oe_o <= 1'b1;
        end else begin
            data2_oe_o <= next_data2_oe;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            left_audio_pin_o <= 1'b0;
        end else begin
            left_audio_pin_o <= next_left;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            right_audio_pin_o <= 1'b0;
        end else begin
            right_audio_pin_o <= next_right;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            se_rx_enable_o <= 1'b1;
        end else begin
            se_rx_enable_o <= ~audio_on;
        end
    end

endmodule : uirq_regs

// ### verif/test_uirq_regs.sv
`timescale 1ns/1ps
module test_uirq_regs;
    import uirq_pkg::*;
    logic        clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, err_o, e;
    logic [7:0]  adr_i, r, v;
    logic [3:0]  sel_i;
    logic [31:0] dat_i, dat_o;
    uirq_src_t   src_i;
    logic [1:0]  line_state_i;
    logic        id_float_i, vdat_det_i, accessory_exit_i, uart_txd_i;
    logic        dp_rx_i, irq_event_o, alt_int_o, accessory_mode_entry_o;
    logic        id_pin_ground_drive_o, dm_txd_route_o, dm_txd_o;
    logic        dp_rxd_route_o, data1_o, data2_o, data2_oe_o;
    logic        left_audio_pin_o, right_audio_pin_o, se_rx_enable_o;
    logic [7:0]  exp_q[$];
    int          n_mismatch, tests_run, cyc_cnt, alt_cnt, irq_cnt;
    localparam logic [7:0] BASE [4] = '{8'h10, 8'h16, 8'h19, 8'h1D};
    localparam logic [7:0] MASK [4] = '{8'h1F, 8'hFF, 8'hFE, 8'h07};

    uirq_regs uut (.*);
    uirq_link_model lm (.clk_i(clk_i), .ack_i(ack_o), .err_i(err_o),
        .cyc_o(cyc_i), .stb_o(stb_i), .we_o(we_i), .adr_o(adr_i),
        .dat_o(dat_i));

    initial begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end

    task automatic finish_test();
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : finish_test

    task automatic chk(input logic [7:0] got, input logic [7:0] ex);
        tests_run++;
        if (got !== ex) begin
            n_mismatch++;
            $display("CHECK FAILED %0t got %h exp %h", $time, got, ex);
        end
    endtask : chk

    task automatic rd(input logic [7:0] a, input logic [7:0] ex);
        exp_q.push_back(ex);
        lm.xfer(1'b0, a, 8'h00, e);
    endtask : rd

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        lm.xfer(1'b1, a, d, e);
    endtask : wr

    // read results are judged here, oldest note first
    always @(posedge clk_i) begin
        cyc_cnt <= cyc_cnt + 1;
        alt_cnt <= alt_cnt + int'(alt_int_o);
        irq_cnt <= irq_cnt + int'(irq_event_o);
        if (ack_o && !we_i && exp_q.size() > 0)
            chk(dat_o[7:0], exp_q.pop_front());
        if (cyc_cnt == 5000) begin
            n_mismatch++;
            finish_test();
        end
    end

    initial begin
        rst_i = 1'b1;
        sel_i = 4'hF;
        {src_i, line_state_i, id_float_i, vdat_det_i} = '0;
        {accessory_exit_i, uart_txd_i, dp_rx_i} = '0;
        void'($urandom(25));
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        for (int i = 0; i < 4; i++) begin
            r = 8'($urandom());
            v = 8'($urandom());
            rd(BASE[i], (i == 0) ? 8'h1F : 8'h00);
            wr(BASE[i], r);
            rd(BASE[i] + 8'h1, r & MASK[i]); // load
            wr(BASE[i] + 8'h1, v);
            rd(BASE[i] + 8'h2, (r | v) & MASK[i]); // set
            wr(BASE[i] + 8'h2, r);
            rd(BASE[i], v & ~r & MASK[i]); // clear
        end
        rd(8'h0D, 8'h1F);
        wr(8'h10, 8'h1F);
        rd(8'h14, 8'h00);
        src_i <= 5'h04;
        repeat (3) @(posedge clk_i);
        rd(8'h14, 8'h04); // enabled edge
        rd(8'h14, 8'h00); // read clears
        wr(8'h12, 8'h04);
        src_i <= 5'h00;
        repeat (3) @(posedge clk_i);
        rd(8'h14, 8'h00); // masked edge
        src_i <= 5'h1F;
        repeat (2) @(posedge clk_i);
        rd(8'h13, 8'h15);
        wr(8'h0F, 8'h0A);
        wr(8'h11, 8'h04);
        rd(8'h13, 8'h1F);
        src_i <= 5'h00;
        v = 8'($urandom());
        line_state_i <= v[1:0];
        repeat (2) @(posedge clk_i);
        rd(8'h13, 8'h00);
        rd(8'h15, {6'h00, v[1:0]});
        chk(8'(irq_cnt), 8'h03); // three cycles with enabled edges
        wr(8'h16, 8'h3C);
        sel_i <= 4'hE;
        wr(8'h16, 8'hC3);
        sel_i <= 4'hF;
        rd(8'h16, 8'h3C); // lane 0 off ignores write
        for (int i = 0; i < 8; i++) begin
            r = 8'($urandom());
            r[3:2] = 2'(i);
            v = 8'($urandom());
            uart_txd_i <= v[0];
            dp_rx_i <= v[1];
            wr(8'h19, r);
            repeat (3) @(posedge clk_i);
            chk({4'h0, id_pin_ground_drive_o, dm_txd_route_o,
                 dp_rxd_route_o, dm_txd_o},
                {4'h0, r[1], r[2], r[3], r[2] & v[0]});
            chk({5'h00, data1_o, se_rx_enable_o, right_audio_pin_o},
                {5'h00, r[3] ? v[1] : 1'b1, ~(r[4] | r[5] | r[6]),
                 (r[5] | r[6]) & v[1]});
            chk({7'h00, left_audio_pin_o},
                {7'h00, r[4] & r[2] & v[0]});
        end
        wr(8'h19, 8'h8C); // routing first, audio off
        wr(8'h20, 8'h01);
        repeat (3) @(posedge clk_i);
        chk({5'h00, data2_o, accessory_mode_entry_o, data2_oe_o},
            8'h02);
        accessory_exit_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        accessory_exit_i <= 1'b0;
        chk({6'h00, accessory_mode_entry_o, data2_oe_o}, 8'h01);
        rd(8'h20, 8'h00);
        wr(8'h1D, 8'h00);
        vdat_det_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        chk(8'(alt_cnt), 8'h00);
        wr(8'h1D, 8'h04);
        vdat_det_i <= 1'b0;
        repeat (4) @(posedge clk_i);
        chk(8'(alt_cnt), 8'h01);
        wr(8'h1D, 8'h01);
        id_float_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        id_float_i <= 1'b0;
        repeat (4) @(posedge clk_i);
        chk(8'(alt_cnt), 8'h02); // float on only
        wr(8'h1D, 8'h02);
        id_float_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        id_float_i <= 1'b0;
        repeat (4) @(posedge clk_i);
        chk(8'(alt_cnt), 8'h03); // float off only
        lm.xfer(1'b1, 8'h1C, 8'hFF, e);
        chk({7'h00, e}, 8'h01);
        repeat (2) @(posedge clk_i);
        finish_test();
    end
endmodule : test_uirq_regs

// ### verif/uirq_link_model.sv
`timescale 1ns/1ps
module uirq_link_model (
    // clock and answer
    input  wire logic        clk_i,
    input  wire logic        ack_i,
    input  wire logic        err_i,
    // request
    output logic             cyc_o,
    output logic             stb_o,
    output logic             we_o,
    output logic [7:0]       adr_o,
    output logic [31:0]      dat_o
);
    initial {cyc_o, stb_o, we_o, adr_o, dat_o} = '0;

    // no cycle count assumed: only the bench timeout ends the wait
    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [7:0] d, output logic e);
        @(posedge clk_i);
        {cyc_o, stb_o, we_o, adr_o} <= {2'b11, w, a};
        dat_o <= {24'h000000, d};
        do @(posedge clk_i); while (!(ack_i || err_i));
        e = err_i;
        {cyc_o, stb_o} <= 2'b00;
    endtask : xfer
endmodule : uirq_link_model

// ### verif/uirq_regs_monitor.sv
`timescale 1ns/1ps
module uirq_regs_monitor
    import uirq_pkg::*;
(
    // bus
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        cyc_i,
    input wire logic        stb_i,
    input wire logic        we_i,
    input wire logic [7:0]  adr_i,
    input wire logic [31:0] dat_o,
    input wire logic        ack_o,
    input wire logic        err_o,
    // live inputs and pins
    input wire uirq_pkg::uirq_src_t src_i,
    input wire logic [1:0]  line_state_i,
    input wire logic        dp_rxd_route_o,
    input wire logic        data1_o,
    input wire logic        accessory_mode_entry_o,
    input wire logic        data2_o,
    input wire logic        data2_oe_o,
    input wire logic        left_audio_pin_o,
    input wire logic        se_rx_enable_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic taken;
    logic rd_ack;
    assign taken = cyc_i && stb_i && !ack_o && !err_o;
    assign rd_ack = ack_o && !we_i;

    ack_pulse_a: assert property (ack_o |=> !ack_o)
        else $error("ack held longer than one cycle");
    bus_answer_a: assert property (taken |=> ack_o ^ err_o)
        else $error("request not answered in one cycle");
    unmapped_err_a: assert property
        (taken && adr_i == 8'h1C |=> err_o && !ack_o)
        else $error("unmapped index not refused");
    latch_top_a: assert property
        (rd_ack && adr_i == 8'h14 |-> dat_o[7:5] == 3'h0)
        else $error("latch upper bits not zero");
    line_view_a: assert property
        (rd_ack && adr_i == 8'h15 |->
            dat_o[7:0] == {6'h00, $past(line_state_i)})
        else $error("line view wrong");
    sess_live_a: assert property
        (rd_ack && adr_i == 8'h13 |->
            (dat_o[4:0] & 5'h04) == ($past(src_i) & 5'h04))
        else $error("session valid status not live");
    rx_idle_a: assert property
        (!dp_rxd_route_o && !$past(dp_rxd_route_o) |-> data1_o)
        else $error("data1 not high without rx routing");
    data2_drive_a: assert property
        (!accessory_mode_entry_o && !$past(accessory_mode_entry_o) |->
            data2_oe_o && !data2_o)
        else $error("data2 not driven low outside mode");
    se_rx_off_a: assert property
        (left_audio_pin_o && $past(left_audio_pin_o) |-> !se_rx_enable_o)
        else $error("receivers on with audio switch");
endmodule : uirq_regs_monitor

bind uirq_regs uirq_regs_monitor chk_i (.*);
